/* hw/sfd_special_decoder.sv */
`timescale 1ns/1ps

// Overview of operation
// - signed compare: result word bit 0 set and zero detect false gives condition code 01
// - signed compare: zero detect true gives condition code 10
// - signed compare: bit 0 clear and not zero gives condition code 00
// - character class: operand bits 8 to 15 special character gives 01
// - character class: letter gives 10, digit gives 00
// - equal code always loads condition code 10
// - greater code always loads condition code 00
// - less code always loads condition code 01
// - status clear: operand bits 0, 1, 2 set clear halt, run and system halt
// - status clear: bits 4-7 octal selector clears one source or reverses parity
// - status clear: bits 10,11,12,14,15 force set, clear flags, freeze, panel clear
// - carry clear code clears the status carry bit
// - zero test: zero detect gives 10, otherwise 00
module sfd_special_decoder
  import sfd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       micro_en,
  input  wire logic [4:0] special_field,
  input  wire logic [0:15] t_bus,
  input  wire logic       t_zero,
  input  wire logic [0:15] u_bus,
  input  wire logic       carry_set,
  input  wire sfd_isr_s   isr_set,
  output logic      [1:0] cond_code,
  output logic            carry,
  output sfd_isr_s        interrupt_status_reg,
  output sfd_diag_s       diag_out,
  output logic            special_busy
);

  // ----------------------------------------------------------------
  // function: octal selector to status clear mask
  // ----------------------------------------------------------------
  function automatic sfd_isr_s sel_clear_mask(input logic [3:0] sel);
    sfd_isr_s m;
    m = sfd_isr_s'(SFD_ISR_RESET);
    case (sel)
      SFD_SEL_BOUNDS: begin
        m.bounds_violation = 1'b1;
      end
      SFD_SEL_ILL_ADDR: begin
        m.illegal_address = 1'b1;
      end
      SFD_SEL_TIMER: begin
        m.cpu_timer = 1'b1;
      end
      SFD_SEL_SYS_PAR: begin
        m.sys_parity = 1'b1;
      end
      SFD_SEL_ADDR_PAR: begin
        m.addr_parity = 1'b1;
      end
      SFD_SEL_DATA_PAR: begin
        m.data_parity = 1'b1;
      end
      SFD_SEL_MODULE: begin
        m.module_intr = 1'b1;
      end
      SFD_SEL_EXTERNAL: begin
        m.ext_intr = 1'b1;
      end
      SFD_SEL_POWER_FAIL: begin
        m.power_fail = 1'b1;
      end
      default: begin
        m = sfd_isr_s'(SFD_ISR_RESET);  // nop and unused selector values
      end
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // decode of the special field
  // ----------------------------------------------------------------
  sfd_code_e  code;
  logic       do_signed_cmp;
  logic       do_char_class;
  logic       do_equal;
  logic       do_greater;
  logic       do_less;
  logic       do_zero_test;
  logic       do_intr_clr;
  logic       do_carry_clear;
  logic [1:0] char_cc;
  logic [3:0] octal_sel;

  // codes outside this block decode to no action here
  always_comb begin
    code           = sfd_code_e'(special_field);
    do_signed_cmp  = 1'b0;
    do_char_class  = 1'b0;
    do_equal       = 1'b0;
    do_greater     = 1'b0;
    do_less        = 1'b0;
    do_zero_test   = 1'b0;
    do_intr_clr    = 1'b0;
    do_carry_clear = 1'b0;
    octal_sel      = u_bus[SFD_UB_SEL_MSB:SFD_UB_SEL_LSB];
    // a microcycle without the enable decodes no action; hardware sets still reach carry and status
    if (micro_en) begin
      case (code)
        SFD_CC_SIGNED_CMP: begin
          do_signed_cmp = 1'b1;
        end
        SFD_CHAR_CLASS: begin
          do_char_class = 1'b1;
        end
        SFD_CC_EQUAL: begin
          do_equal = 1'b1;
        end
        SFD_CC_GREATER: begin
          do_greater = 1'b1;
        end
        SFD_CC_LESS: begin
          do_less = 1'b1;
        end
        SFD_CC_ZERO_TEST: begin
          do_zero_test = 1'b1;
        end
        SFD_INTR_CLR: begin
          do_intr_clr = 1'b1;
        end
        SFD_CARRY_CLEAR: begin
          do_carry_clear = 1'b1;
        end
        default: begin
          do_signed_cmp = 1'b0;
        end
      endcase
    end
  end

  // character classifier on operand bits 8..15
  sfd_char_class u_char_class (
    .ascii_char (u_bus[SFD_UB_CHAR_MSB:SFD_UB_CHAR_LSB]),
    .char_cc    (char_cc)
  );

  // ----------------------------------------------------------------
  // condition code
  // ----------------------------------------------------------------
  logic [1:0] next_cond_code;

  // zero detect is checked before sign so a stray sign bit on a zero
  // word cannot report less
  always_comb begin
    next_cond_code = cond_code;
    if (do_signed_cmp) begin
      if (t_zero) begin
        next_cond_code = SFD_CC_EQ;
      end else if (t_bus[SFD_TB_SIGN]) begin
        next_cond_code = SFD_CC_LT;
      end else begin
        next_cond_code = SFD_CC_GT;
      end
    end else if (do_char_class) begin
      next_cond_code = char_cc;
    end else if (do_equal) begin
      next_cond_code = SFD_CC_EQ;
    end else if (do_greater) begin
      next_cond_code = SFD_CC_GT;
    end else if (do_less) begin
      next_cond_code = SFD_CC_LT;
    end else if (do_zero_test) begin
      next_cond_code = t_zero ? SFD_CC_EQ : SFD_CC_GT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cond_code <= SFD_CC_RESET;
    end else begin
      cond_code <= next_cond_code;
    end
  end

  // ----------------------------------------------------------------
  // carry bit of the status register
  // ----------------------------------------------------------------
  logic next_carry;

  // an alu carry arriving with the clear code wins
  always_comb begin
    next_carry = carry;
    if (do_carry_clear) begin
      next_carry = 1'b0;
    end
    // set looked at last so it overrides a clear in the same cycle
    if (carry_set) begin
      next_carry = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      carry <= SFD_CARRY_RESET;
    end else begin
      carry <= next_carry;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status register
  // ----------------------------------------------------------------
  sfd_isr_s   clr_mask;
  sfd_isr_s   force_mask;
  sfd_isr_s   next_isr;
  logic [13:0] isr_vec;

  // clear mask from the operand word; bit 3 and bits 8, 9, 13 ignored
  always_comb begin
    clr_mask   = sfd_isr_s'(SFD_ISR_RESET);
    force_mask = sfd_isr_s'(SFD_ISR_RESET);
    if (do_intr_clr) begin
      clr_mask = sel_clear_mask(octal_sel);
      clr_mask.halt     = u_bus[SFD_UB_HALT];
      clr_mask.run      = u_bus[SFD_UB_RUN];
      clr_mask.sys_halt = u_bus[SFD_UB_SYS_HALT];
      clr_mask.interrupt_stack_flag = u_bus[SFD_UB_CLR_ISTACK];
      clr_mask.dispatcher_flag      = u_bus[SFD_UB_CLR_DISP];
      // diagnostic set is ored in after the clear, so it wins
      if (u_bus[SFD_UB_DIAG_SET]) begin
        force_mask = sfd_isr_s'(SFD_ISR_DIAG_MASK);
      end
    end
  end

  // hardware events set after the clear, so a set never gets lost
  always_comb begin
    isr_vec  = (interrupt_status_reg & ~clr_mask) | force_mask | isr_set;
    next_isr = sfd_isr_s'(isr_vec);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      interrupt_status_reg <= sfd_isr_s'(SFD_ISR_RESET);
    end else begin
      interrupt_status_reg <= next_isr;
    end
  end

  // ----------------------------------------------------------------
  // parity reversal modes and diagnostic pulses
  // ----------------------------------------------------------------
  sfd_diag_s next_diag;

  // parity reversal toggles a held mode; freeze and panel clear are
  // one-microcycle pulses, registered so they are glitch free
  always_comb begin
    next_diag             = diag_out;
    next_diag.diag_freeze = 1'b0;
    next_diag.panel_clear = 1'b0;
    if (do_intr_clr) begin
      if (octal_sel == SFD_SEL_REV_SYS) begin
        next_diag.sys_parity_reverse = ~diag_out.sys_parity_reverse;
      end
      if (octal_sel == SFD_SEL_REV_CU) begin
        next_diag.control_unit_parity_reverse =
          ~diag_out.control_unit_parity_reverse;
      end
      // pulses follow the operand bits only on the clear code
      next_diag.diag_freeze = u_bus[SFD_UB_FREEZE];
      next_diag.panel_clear = u_bus[SFD_UB_PANEL_CLR];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      diag_out <= sfd_diag_s'(SFD_DIAG_RESET);
    end else begin
      diag_out <= next_diag;
    end
  end

  // ----------------------------------------------------------------
  // activity indication
  // ----------------------------------------------------------------
  logic next_busy;

  // high for the cycle after any recognised action was taken
  always_comb begin
    next_busy = do_signed_cmp || do_char_class || do_equal || do_greater ||
                do_less || do_zero_test || do_intr_clr || do_carry_clear;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      special_busy <= 1'b0;
    end else begin
      special_busy <= next_busy;
    end
  end

endmodule

/* hw/sfd_pkg.sv */
package sfd_pkg;

  // ----------------------------------------------------------------
  // special field codes handled here
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SFD_CHAR_CLASS     = 5'h00,
    SFD_INTR_CLR       = 5'h01,
    SFD_CARRY_CLEAR    = 5'h15,
    SFD_CC_ZERO_TEST   = 5'h1A,
    SFD_CC_LESS        = 5'h1B,
    SFD_CC_GREATER     = 5'h1C,
    SFD_CC_EQUAL       = 5'h1D,
    SFD_CC_SIGNED_CMP  = 5'h1E,
    SFD_NO_ACTION      = 5'h1F
  } sfd_code_e;

  // ----------------------------------------------------------------
  // condition code values
  // ----------------------------------------------------------------
  localparam logic [1:0] SFD_CC_GT = 2'h0;  // greater
  localparam logic [1:0] SFD_CC_LT = 2'h1;  // less
  localparam logic [1:0] SFD_CC_EQ = 2'h2;  // equal
  localparam logic [1:0] SFD_CC_RESET = 2'h0;

  // ----------------------------------------------------------------
  // operand-bus field positions (bit 0 is the most significant)
  // ----------------------------------------------------------------
  localparam int SFD_UB_HALT       = 0;
  localparam int SFD_UB_RUN        = 1;
  localparam int SFD_UB_SYS_HALT   = 2;
  localparam int SFD_UB_SEL_MSB    = 4;
  localparam int SFD_UB_SEL_LSB    = 7;
  localparam int SFD_UB_CHAR_MSB   = 8;
  localparam int SFD_UB_CHAR_LSB   = 15;
  localparam int SFD_UB_DIAG_SET   = 10;
  localparam int SFD_UB_CLR_ISTACK = 11;
  localparam int SFD_UB_CLR_DISP   = 12;
  localparam int SFD_UB_FREEZE     = 14;
  localparam int SFD_UB_PANEL_CLR  = 15;
  localparam int SFD_TB_SIGN       = 0;

  // ----------------------------------------------------------------
  // octal selector values
  // ----------------------------------------------------------------
  localparam logic [3:0] SFD_SEL_NOP        = 4'h0;
  localparam logic [3:0] SFD_SEL_BOUNDS     = 4'h1;
  localparam logic [3:0] SFD_SEL_ILL_ADDR   = 4'h2;
  localparam logic [3:0] SFD_SEL_TIMER      = 4'h3;
  localparam logic [3:0] SFD_SEL_SYS_PAR    = 4'h4;
  localparam logic [3:0] SFD_SEL_ADDR_PAR   = 4'h5;
  localparam logic [3:0] SFD_SEL_DATA_PAR   = 4'h6;
  localparam logic [3:0] SFD_SEL_MODULE     = 4'h7;
  localparam logic [3:0] SFD_SEL_EXTERNAL   = 4'h8;  // octal 10
  localparam logic [3:0] SFD_SEL_POWER_FAIL = 4'h9;  // octal 11
  localparam logic [3:0] SFD_SEL_REV_SYS    = 4'hE;  // octal 16
  localparam logic [3:0] SFD_SEL_REV_CU     = 4'hF;  // octal 17

  // ----------------------------------------------------------------
  // ascii ranges for character classing
  // ----------------------------------------------------------------
  localparam logic [7:0] SFD_ASC_DIGIT_LO = 8'h30;
  localparam logic [7:0] SFD_ASC_DIGIT_HI = 8'h39;
  localparam logic [7:0] SFD_ASC_UPPER_LO = 8'h41;
  localparam logic [7:0] SFD_ASC_UPPER_HI = 8'h5A;
  localparam logic [7:0] SFD_ASC_LOWER_LO = 8'h61;
  localparam logic [7:0] SFD_ASC_LOWER_HI = 8'h7A;

  // ----------------------------------------------------------------
  // interrupt status register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic halt;
    logic run;
    logic sys_halt;
    logic bounds_violation;
    logic illegal_address;
    logic cpu_timer;
    logic sys_parity;
    logic addr_parity;
    logic data_parity;
    logic module_intr;
    logic ext_intr;
    logic power_fail;
    logic interrupt_stack_flag;
    logic dispatcher_flag;
  } sfd_isr_s;

  localparam logic [13:0] SFD_ISR_RESET = 14'h0000;
  // bits forced by the diagnostic set: the error and interrupt group
  localparam logic [13:0] SFD_ISR_DIAG_MASK = 14'h07FC;
  localparam logic SFD_CARRY_RESET = 1'b0;

  // diagnostic pulses and parity modes leaving the decoder
  typedef struct packed {
    logic sys_parity_reverse;
    logic control_unit_parity_reverse;
    logic diag_freeze;
    logic panel_clear;
  } sfd_diag_s;

  localparam logic [3:0] SFD_DIAG_RESET = 4'h0;

endpackage

/* hw/sfd_char_class.sv */
`timescale 1ns/1ps

module sfd_char_class
  import sfd_pkg::*;
(
  input  wire logic [7:0] ascii_char,
  output logic      [1:0] char_cc
);

  // ----------------------------------------------------------------
  // classify one character
  // ----------------------------------------------------------------
  logic is_digit;
  logic is_alpha;

  // anything neither letter nor digit counts as special, controls too
  always_comb begin
    is_digit = (ascii_char >= SFD_ASC_DIGIT_LO) && (ascii_char <= SFD_ASC_DIGIT_HI);
    is_alpha = ((ascii_char >= SFD_ASC_UPPER_LO) && (ascii_char <= SFD_ASC_UPPER_HI)) ||
               ((ascii_char >= SFD_ASC_LOWER_LO) && (ascii_char <= SFD_ASC_LOWER_HI));
    if (is_alpha) begin
      char_cc = SFD_CC_EQ;
    end else if (is_digit) begin
      char_cc = SFD_CC_GT;
    end else begin
      char_cc = SFD_CC_LT;
    end
  end

endmodule

/* tb/sfd_checker.sv */
`timescale 1ns/1ps
// ----
// port checker
// ----
module sfd_checker
  import sfd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        micro_en,
  input wire logic [4:0]  special_field,
  input wire logic [0:15] t_bus,
  input wire logic        t_zero,
  input wire logic [0:15] u_bus,
  input wire logic        carry_set,
  input wire sfd_isr_s    isr_set,
  input wire logic [1:0]  cond_code,
  input wire logic        carry,
  input wire sfd_isr_s    interrupt_status_reg,
  input wire sfd_diag_s   diag_out,
  input wire logic        special_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // one taken microcycle carrying a given code
  sequence s_code(logic [4:0] c);
    micro_en && special_field == c;
  endsequence
  a_idle_hold: assert property (s_code(5'h1F) ##0 (!carry_set && isr_set == '0) |=>
    $stable(cond_code) && $stable(carry) && $stable(interrupt_status_reg))
    else $error("no-action code changed state");
  a_signed_cmp: assert property (s_code(5'h1E) |=> cond_code ==
    ($past(t_zero) ? SFD_CC_EQ : ($past(t_bus[0]) ? SFD_CC_LT : SFD_CC_GT)))
    else $error("signed compare gave wrong code");
  a_equal_load: assert property (s_code(5'h1D) |=> cond_code == SFD_CC_EQ)
    else $error("equal load wrong");
  a_greater_load: assert property (s_code(5'h1C) |=> cond_code == SFD_CC_GT)
    else $error("greater load wrong");
  a_less_load: assert property (s_code(5'h1B) |=> cond_code == SFD_CC_LT)
    else $error("less load wrong");
  a_zero_test: assert property (s_code(5'h1A) |=>
    cond_code == ($past(t_zero) ? SFD_CC_EQ : SFD_CC_GT))
    else $error("zero test gave wrong code");
  a_carry_clear: assert property (s_code(5'h15) ##0 !carry_set |=> !carry)
    else $error("carry not cleared");
  a_halt_clear: assert property (s_code(5'h01) ##0 (u_bus[0] && !isr_set.halt) |=>
    !interrupt_status_reg.halt)
    else $error("halt not cleared");
  a_parity_flip: assert property (s_code(5'h01) ##0 u_bus[4:7] == SFD_SEL_REV_SYS |=>
    diag_out.sys_parity_reverse != $past(diag_out.sys_parity_reverse))
    else $error("system parity reverse did not toggle");
  a_quiet_idle: assert property (!micro_en |=>
    !special_busy && !diag_out.diag_freeze && !diag_out.panel_clear)
    else $error("pulse without a taken code");
endmodule

bind sfd_special_decoder sfd_checker i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .micro_en(micro_en),
  .special_field(special_field), .t_bus(t_bus), .t_zero(t_zero), .u_bus(u_bus),
  .carry_set(carry_set), .isr_set(isr_set), .cond_code(cond_code), .carry(carry),
  .interrupt_status_reg(interrupt_status_reg), .diag_out(diag_out),
  .special_busy(special_busy)
);

/* tb/sfd_hw_src.sv */
`timescale 1ns/1ps
// ----
// hardware set pulse source
// ----
module sfd_hw_src
  import sfd_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     sys_rst,
  input  wire sfd_isr_s req_isr,
  input  wire logic     req_carry,
  output sfd_isr_s      isr_set,
  output logic          carry_set
);
  sfd_isr_s next_isr_set;
  logic     next_carry_set;
  // pulse width follows the request, which the bench holds one cycle
  always_comb begin
    next_isr_set   = sys_rst ? sfd_isr_s'(SFD_ISR_RESET) : req_isr;
    next_carry_set = sys_rst ? 1'b0 : req_carry;
  end
  always_ff @(posedge core_clk) begin
    isr_set   <= next_isr_set;
    carry_set <= next_carry_set;
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
// ----
// bench
// ----
module tb;
  import sfd_pkg::*;
  logic        core_clk, sys_rst, micro_en, t_zero, req_carry, carry_set, carry, special_busy;
  logic [4:0]  special_field;
  logic [0:15] t_bus, u_bus;
  logic [1:0]  cond_code;
  logic [13:0] exp;
  logic [7:0]  ch [11] = '{8'h41, 8'h5A, 8'h61, 8'h7A, 8'h30, 8'h39,
                           8'h40, 8'h5B, 8'h2F, 8'h3A, 8'hC1};
  sfd_isr_s    req_isr, isr_set, interrupt_status_reg;
  sfd_diag_s   diag_out;
  int          n_mismatch, checked, s;

  sfd_special_decoder i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .micro_en(micro_en),
    .special_field(special_field), .t_bus(t_bus), .t_zero(t_zero), .u_bus(u_bus),
    .carry_set(carry_set), .isr_set(isr_set), .cond_code(cond_code), .carry(carry),
    .interrupt_status_reg(interrupt_status_reg), .diag_out(diag_out),
    .special_busy(special_busy));
  sfd_hw_src i_hw (.core_clk(core_clk), .sys_rst(sys_rst), .req_isr(req_isr),
    .req_carry(req_carry), .isr_set(isr_set), .carry_set(carry_set));

  // 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk_w(input logic [13:0] got, input logic [13:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic chk_cc(input logic [1:0] got, input logic [1:0] want);
    chk_w({12'h000, got}, {12'h000, want});
  endtask
  // one taken microcycle, results looked at once the edge has landed
  task automatic op(input logic [4:0] c, input logic [15:0] t, input logic tz,
                    input logic [15:0] u);
    @(posedge core_clk);
    micro_en      <= 1'b1;
    special_field <= c;
    t_bus         <= t;
    t_zero        <= tz;
    u_bus         <= u;
    @(posedge core_clk);
    micro_en <= 1'b0;
    #1;
    chk_w({13'h0000, special_busy},
          {13'h0000, (c inside {5'h00, 5'h01, 5'h15, [5'h1A:5'h1E]})});
  endtask
  // request a one-cycle hardware set pulse from the partner
  task automatic hw_set(input logic [13:0] v, input logic c);
    @(posedge core_clk);
    req_isr   <= v;
    req_carry <= c;
    @(posedge core_clk);
    req_isr   <= '0;
    req_carry <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the sequence needs well under 400 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1; micro_en = 1'b0; special_field = 5'h1F; t_bus = '0; t_zero = 1'b0;
    u_bus = '0; req_isr = '0; req_carry = 1'b0; n_mismatch = 0; checked = 0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk_w({6'h00, cond_code, carry, diag_out, special_busy}, 14'h0000);
    // fixed loads ignore a zero result word, negative for equal and greater
    op(5'h1D, 16'h8000, 1'b1, '0); chk_cc(cond_code, 2'h2);
    op(5'h1C, 16'h8000, 1'b1, '0); chk_cc(cond_code, 2'h0);
    op(5'h1B, 16'h0000, 1'b1, '0); chk_cc(cond_code, 2'h1);
    op(5'h1E, 16'h8000, 1'b0, '0); chk_cc(cond_code, 2'h1);
    op(5'h1E, 16'h8000, 1'b1, '0); chk_cc(cond_code, 2'h2);
    op(5'h1E, 16'h0000, 1'b1, '0); chk_cc(cond_code, 2'h2);
    op(5'h1E, 16'h7FFF, 1'b0, '0); chk_cc(cond_code, 2'h0);
    op(5'h1A, 16'h0000, 1'b1, '0); chk_cc(cond_code, 2'h2);
    op(5'h1A, 16'h8000, 1'b0, '0); chk_cc(cond_code, 2'h0);
    // letters, digits, then neighbours of the upper-case and digit ranges and 8'hC1
    for (int i = 0; i < 11; i++) begin
      op(5'h00, '0, 1'b1, {8'hFF, ch[i]});
      chk_cc(cond_code, (i < 4) ? 2'h2 : ((i < 6) ? 2'h0 : 2'h1));
    end
    op(5'h1F, '0, 1'b1, 16'hFFFF); chk_cc(cond_code, 2'h1);
    op(5'h12, '0, 1'b1, 16'hFFFF); chk_cc(cond_code, 2'h1);
    hw_set('0, 1'b1); chk_w({13'h0000, carry}, 14'h0001);
    op(5'h1F, '0, 1'b0, '0); chk_w({13'h0000, carry}, 14'h0001);
    op(5'h15, '0, 1'b0, '0); chk_w({13'h0000, carry}, 14'h0000);
    // status clears, selector walk, ignored bits, diagnostics
    hw_set(14'h3FFF, 1'b0); exp = 14'h3FFF;
    op(5'h01, '0, 1'b0, 16'h9100); exp = 14'h1BFF; chk_w(interrupt_status_reg, exp);
    for (s = 2; s < 10; s++) begin
      op(5'h01, '0, 1'b0, {4'h0, s[3:0], 8'h00});
      exp[11-s] = 1'b0;
      chk_w(interrupt_status_reg, exp);
    end
    op(5'h01, '0, 1'b0, 16'h1AC4); chk_w(interrupt_status_reg, 14'h1803);
    op(5'h01, '0, 1'b0, 16'h6018); chk_w(interrupt_status_reg, 14'h0000);
    op(5'h01, '0, 1'b0, 16'h0020); chk_w(interrupt_status_reg, 14'h07FC);
    op(5'h01, '0, 1'b0, 16'h0003);
    chk_w({12'h000, diag_out.diag_freeze, diag_out.panel_clear}, 14'h0003);
    @(posedge core_clk);
    #1;
    chk_w({12'h000, diag_out.diag_freeze, diag_out.panel_clear}, 14'h0000);
    op(5'h01, '0, 1'b0, 16'h0E00); chk_w({10'h000, diag_out}, 14'h0008);
    op(5'h01, '0, 1'b0, 16'h0F00); chk_w({10'h000, diag_out}, 14'h000C);
    op(5'h01, '0, 1'b0, 16'h0E00); chk_w({10'h000, diag_out}, 14'h0004);
    // reset in mid-run clears everything again
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk_w({6'h00, cond_code, carry, diag_out, special_busy}, 14'h0000);
    chk_w(interrupt_status_reg, 14'h0000);
    wrap_up();
  end
endmodule
